// ===== bench/gsr_mem_model.sv
// Memory side model: answers fetches, takes acknowledges
`timescale 1ns/1ps
module gsr_mem_model (
    input wire core_clk_i, // Clock
    input wire sys_rst_i, // Reset
    input wire fetch_req_o, // Fetch
    input wire ack_valid_o, // Ack
    input wire slow_i, // Stretch answers
    output logic fetch_done_i, // Done pulse
    output logic ack_ready_i // Ack taken
);
    logic [3:0] cnt_q;
    always @(posedge core_clk_i) begin
        if (sys_rst_i || !fetch_req_o || fetch_done_i) begin
            cnt_q <= 4'h0;
            fetch_done_i <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            fetch_done_i <= cnt_q == (slow_i ? 4'h9 : 4'h0);
        end
        // Slow mode stalls every other cycle
        ack_ready_i <= !sys_rst_i && (!slow_i || !ack_ready_i);
    end
endmodule

// ===== bench/gsr_unit_asserts.sv
// Port checker for the group service request unit
`timescale 1ns/1ps
module gsr_unit_asserts #(parameter NG = 8, parameter GRP_W = 3) (
    input wire core_clk_i, // Clock
    input wire sys_rst_i, // Reset
    input wire [NG*32-1:0] grp_struct_addr_o, // Bases
    input wire fetch_req_o, // Fetch
    input wire [GRP_W-1:0] fetch_grp_o, // Fetch group
    input wire [31:0] fetch_addr_o, // Fetch address
    input wire fetch_done_i, // Done
    input wire ack_valid_o, // Ack
    input wire [GRP_W-1:0] ack_grp_o, // Group
    input wire [4:0] ack_code_o, // Code
    input wire ack_ready_i, // Taken
    input wire chan_op_valid_o, // Op
    input wire [1:0] chan_op_o // Op kind
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence fetch_end; fetch_req_o && fetch_done_i; endsequence
    sequence ack_wait; ack_valid_o && !ack_ready_i; endsequence
    sequence ack_take; ack_valid_o && ack_ready_i; endsequence
    base_align_a: assert property (grp_struct_addr_o[10:0] == 11'h000)
        else $error("base low bits set");
    fetch_ack_a: assert property (fetch_end |=> ack_valid_o)
        else $error("no ack after fetch");
    fetch_drop_a: assert property (fetch_end |=> !fetch_req_o)
        else $error("fetch held after done");
    ack_hold_a: assert property (ack_wait |=> ack_valid_o && $stable(ack_grp_o))
        else $error("ack dropped");
    ack_done_a: assert property (ack_take |=> !ack_valid_o)
        else $error("ack repeated");
    no_chip_ack_a: assert property (ack_valid_o |-> ack_code_o != 5'h01)
        else $error("chip reset acked");
    op_ack_a: assert property (chan_op_valid_o |-> ack_code_o inside {8, 9, 10})
        else $error("stray channel op");
    jump_op_a: assert property (chan_op_valid_o && chan_op_o == 2 |-> ack_code_o == 10)
        else $error("deferred op not jump");
    fetch_addr_a: assert property (fetch_req_o |->
        fetch_addr_o == grp_struct_addr_o[fetch_grp_o*32 +: 32])
        else $error("fetch address not group base");
endmodule
bind gsr_unit gsr_unit_asserts #(.NG(NG), .GRP_W(GRP_W)) chk_inst (.*);

// ===== bench/gsr_unit_bench.sv
// Self-checking bench for the group service request unit
`timescale 1ns/1ps
module gsr_unit_bench;
    logic core_clk_i = 0, sys_rst_i = 1, slow_i = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d, rd_v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] gcfg_port_to_group_mapping_i = 0, rsp;
    wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, irq_o;
    wire fetch_req_o, fetch_done_i, ack_valid_o, ack_ready_i, chan_op_valid_o;
    wire fetch_dir_o, chan_dir_o, iq_reset_o;
    wire [1:0] s_axi_bresp, s_axi_rresp, chan_op_o, port_map_o;
    wire [31:0] s_axi_rdata, fetch_addr_o;
    wire [4:0] fetch_code_o, fetch_chan_o, ack_code_o, chan_idx_o;
    wire [2:0] fetch_grp_o, ack_grp_o, chan_grp_o;
    wire [7:0] port_en_o;
    wire [255:0] grp_struct_addr_o, rx_active_o, tx_active_o;
    logic [255:0] act_m[2];
    logic [7:0] pe_m;
    int n_mismatch = 0, tests_run = 0, g, c, dr;
    always #2 core_clk_i = ~core_clk_i;
    gsr_unit #(.LINE_DIV(16'h0004)) gsr_unit_inst (.*);
    gsr_mem_model gsr_mem_model_inst (.*);
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(string nm, logic [255:0] e, logic [255:0] v);
        tests_run++;
        if (v !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %0h got %0h", nm, e, v);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] wd);
        bit aw = 0, w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        repeat (200) begin
            @(posedge core_clk_i);
            if (s_axi_bvalid) begin
                return;
            end
            if (!aw && s_axi_awready) s_axi_awvalid <= 0;
            if (!w && s_axi_wready) s_axi_wvalid <= 0;
            aw |= s_axi_awready;
            w |= s_axi_wready;
        end
        n_mismatch++;
        conclude();
    endtask
    task automatic rd(logic [11:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        repeat (200) begin
            @(posedge core_clk_i);
            if (s_axi_rvalid) begin
                rd_v = s_axi_rdata;
                rsp = s_axi_rresp;
                return;
            end
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        n_mismatch++;
        conclude();
    endtask
    task automatic cmd(int gi, int ci, int di, int ch);
        int i;
        wr(12'(260 + 8 * gi), {ci[4:0], 2'h0, di[0], ch[4:0]});
        case (ci)
            8, 9, 10: act_m[di][gi*32+ch] = ci != 9;
            2: begin
                act_m[0][gi*32+:32] = 0;
                act_m[1][gi*32+:32] = 0;
                pe_m[gi] = 0;
            end
            5, 21: pe_m[gi] = 1;
        endcase
        for (i = 0; i < 200 && !(ack_valid_o === 1'b1 && ack_ready_i === 1'b1); i++)
            @(posedge core_clk_i);
        if (i == 200) begin
            n_mismatch++;
            conclude();
        end
        cmp("ack_grp", gi, ack_grp_o);
        cmp("ack_code", ci, ack_code_o);
        repeat (2) @(posedge core_clk_i);
        cmp("rx_active", act_m[0], rx_active_o);
        cmp("tx_active", act_m[1], tx_active_o);
        cmp("port_en", pe_m, port_en_o);
    endtask
    initial begin
        void'($urandom(32'hbc54_8a1c));
        act_m[0] = 0;
        act_m[1] = 0;
        pe_m = 0;
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 0;
        @(posedge core_clk_i);
        for (g = 0; g < 8; g++) begin
            d = $urandom;
            wr(12'(256 + 8 * g), d);
            rd(12'(256 + 8 * g));
            cmp("base", d & 32'hffff_f800, rd_v);
            cmp("struct_addr", {d[31:11], 11'h000}, grp_struct_addr_o[g*32+:32]);
        end
        rd(12'h300);
        cmp("unmapped", 2, rsp);
        wr(12'h004, 32'h0000_0001);
        cmd(0, 4, 0, 0);
        for (g = 0; g < 16; g++) cmd(g / 2, 5, g % 2, 0);
        // Codes 0 to 23 but chip reset, both directions, prompt and slow memory
        for (c = 0; c < 24; c++)
            for (dr = 0; dr < 2 && c != 1; dr++) begin
                slow_i <= dr[0];
                cmd(c % 8, c, dr, $urandom % 32);
            end
        cmp("irq_set", 1, irq_o);
        wr(12'h004, 32'h0000_0000);
        cmp("irq_masked", 0, irq_o);
        wr(12'h000, 32'h0000_0001);
        wr(12'h004, 32'h0000_0001);
        cmp("irq_clear", 0, irq_o);
        wr(12'h104, 32'h0000_0100);
        repeat (8) @(posedge core_clk_i);
        cmp("rx_chip_rst", 0, rx_active_o);
        cmp("tx_chip_rst", 0, tx_active_o);
        cmp("port_chip_rst", 0, port_en_o);
        rd(12'h000);
        cmp("chip_rst_flag", 32'h0000_0002, rd_v);
        conclude();
    end
endmodule

// ===== hw/gsr_defs.vh
// Constants for the group service request unit
// Summary of operation
// R1: Structure address is base bits 31:11 followed by eleven zero bits.
// R2: Low eleven bits of each group base register always hold zero.
// R3: Each group structure configures one group and its 32 channels.
// R4: Every accepted command except soft chip reset returns a tagged acknowledge.
// R5: Soft chip reset is never acknowledged and completes within two line periods.
// R6: Host waits for acknowledge before issuing another command to that group.
// R7: One outstanding command per group; acknowledges carry the group identity.
// R8: Code 0 does nothing except produce the acknowledge.
// R9: Code 1 clears port mapping, ports, all channels, queue pointer, indicators.
// R10: Code 2 disables the group's port and deactivates its 32 channels.
// R11: Code 4 fetches global and queue descriptors and resets the queue pointer.
// R12: Host issues global initialisation after any reset before relying on it.
// R13: Code 5 fetches the group's maps and configuration descriptors.
// R14: Host runs group initialisation per group and direction after resets.
// R15: Code 8 activates a channel aborting any message; code 9 suspends it.
// R16: Code 10 activates receivers; transmitters switch lists after current message.
// R17: Code 11 reads channel configuration; codes 16 to 21 reread descriptors.
// R18: Reserved codes change no state and are acknowledged like a no-operation.
`ifndef GSR_DEFS_VH
`define GSR_DEFS_VH

// Register byte offsets
`define GSR_OFF_IRQ_STAT 12'h000
`define GSR_OFF_IRQ_MASK 12'h004
`define GSR_OFF_BUSY 12'h008
`define GSR_OFF_PORTS 12'h00C
`define GSR_REGION_GROUP 4'h1
`define GSR_REGION_CHAN 4'h2

// Group base register
`define GSR_BASE_MASK 32'hFFFF_F800
`define GSR_BASE_LSB 11

// Command register fields
`define GSR_CMD_MASK 32'h0000_1F3F
`define GSR_CODE_HI 12
`define GSR_CODE_LO 8
`define GSR_DIR_BIT 5
`define GSR_CHAN_HI 4
`define GSR_CHAN_LO 0

// Command codes
`define GSR_C_NOP 5'h00
`define GSR_C_CHIP_RST 5'h01
`define GSR_C_GRP_RST 5'h02
`define GSR_C_GLOBAL_INIT 5'h04
`define GSR_C_GROUP_INIT 5'h05
`define GSR_C_ACTIVATE 5'h08
`define GSR_C_DEACTIVATE 5'h09
`define GSR_C_JUMP 5'h0A
`define GSR_C_CHAN_CFG 5'h0B
`define GSR_C_RD_GLOBAL 5'h10
`define GSR_C_RD_IRQQ 5'h11
`define GSR_C_RD_PORT 5'h15

// Channel operations toward the datapath
`define GSR_OP_ACTIVATE 2'h0
`define GSR_OP_DEACTIVATE 2'h1
`define GSR_OP_JUMP_DEFER 2'h2

// Interrupt status bits
`define GSR_IRQ_ACK 0
`define GSR_IRQ_CHIP_RST 1
`define GSR_IRQ_OVERLAP 2
`define GSR_IRQ_W 3

// Sequencer states
`define GSR_ST_IDLE 2'h0
`define GSR_ST_FETCH 2'h1
`define GSR_ST_ACK 2'h2

// AXI responses
`define GSR_RESP_OKAY 2'h0
`define GSR_RESP_SLVERR 2'h2

// Line clock: core clock cycles per line clock period
`define GSR_LINE_DIV 16'h0040

`endif

// ===== hw/gsr_line_tick.v
// Line clock rate divider giving a one-cycle enable
`timescale 1ns/1ps
module gsr_line_tick #(
    parameter [15:0] DIV = 16'h0040
) (
    input wire core_clk_i, // Core clock
    input wire sys_rst_i,  // Synchronous reset, active high
    output reg tick_o      // One pulse per line clock period
);
    reg [15:0] cnt_q;

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_q == DIV - 16'h0001) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== hw/gsr_unit.v
// Group service request unit with AXI4-Lite register slave
`timescale 1ns/1ps
`include "gsr_defs.vh"
module gsr_unit #(
    parameter NG = 8,
    parameter GRP_W = 3,
    parameter NCH = 32,
    parameter [15:0] LINE_DIV = `GSR_LINE_DIV
) (
    input wire core_clk_i,               // Core clock, 250 MHz
    input wire sys_rst_i,                // Synchronous reset, active high
    input wire [11:0] s_axi_awaddr,      // Write address
    input wire s_axi_awvalid,            // Write address valid
    output wire s_axi_awready,           // Write address ready
    input wire [31:0] s_axi_wdata,       // Write data
    input wire [3:0] s_axi_wstrb,        // Write byte strobes
    input wire s_axi_wvalid,             // Write data valid
    output wire s_axi_wready,            // Write data ready
    output reg [1:0] s_axi_bresp,        // Write response
    output reg s_axi_bvalid,             // Write response valid
    input wire s_axi_bready,             // Write response ready
    input wire [11:0] s_axi_araddr,      // Read address
    input wire s_axi_arvalid,            // Read address valid
    output wire s_axi_arready,           // Read address ready
    output reg [31:0] s_axi_rdata,       // Read data
    output reg [1:0] s_axi_rresp,        // Read response
    output reg s_axi_rvalid,             // Read data valid
    input wire s_axi_rready,             // Read data ready
    output wire irq_o,                   // Level interrupt
    output wire [NG*32-1:0] grp_struct_addr_o, // Per group structure address
    output reg fetch_req_o,              // Descriptor fetch request
    output reg [4:0] fetch_code_o,       // Command code that asks the fetch
    output reg [GRP_W-1:0] fetch_grp_o,  // Group of the fetch
    output reg fetch_dir_o,              // Direction of the fetch
    output reg [4:0] fetch_chan_o,       // Channel of the fetch
    output reg [31:0] fetch_addr_o,      // Group structure address
    input wire fetch_done_i,             // Fetch finished pulse
    input wire [1:0] gcfg_port_to_group_mapping_i,     // Port mapping from global descriptor
    output reg ack_valid_o,              // Acknowledge descriptor valid
    output reg [GRP_W-1:0] ack_grp_o,    // Group identity of acknowledge
    output reg [4:0] ack_code_o,         // Code being acknowledged
    input wire ack_ready_i,              // Acknowledge written to host
    output reg chan_op_valid_o,          // Channel operation pulse
    output reg [1:0] chan_op_o,          // Channel operation
    output reg [GRP_W-1:0] chan_grp_o,   // Channel operation group
    output reg chan_dir_o,               // Channel operation direction
    output reg [4:0] chan_idx_o,         // Channel operation channel
    output reg iq_reset_o,               // Queue pointer and indicator reset pulse
    output reg [1:0] port_map_o,         // Port to group mapping
    output reg [NG-1:0] port_en_o,       // Port enables, both directions
    output reg [NG*NCH-1:0] rx_active_o, // Receive channel active flags
    output reg [NG*NCH-1:0] tx_active_o  // Transmit channel active flags
);
    reg [31:0] base_q [0:NG-1];
    reg [31:0] cmd_q [0:NG-1];
    reg [NG-1:0] pend_q;
    reg [1:0] state_q;
    reg [GRP_W-1:0] cur_grp_q;
    reg [31:0] cur_cmd_q;
    reg chip_rst_pend_q;
    reg [`GSR_IRQ_W-1:0] irq_stat_q;
    reg [`GSR_IRQ_W-1:0] irq_mask_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire line_tick;
    wire do_wr;
    wire [4:0] wr_idx;
    wire wr_grp_hit;
    wire [31:0] wr_merged;
    wire [4:0] new_code;
    wire [4:0] cur_code;
    wire cur_dir;
    wire [4:0] cur_chan;
    reg pick_found;
    reg [GRP_W-1:0] pick_grp;
    reg needs_fetch;
    reg [31:0] rd_data;
    reg rd_ok;
    reg [`GSR_IRQ_W-1:0] irq_set;
    integer i;
    integer j;

    gsr_line_tick #(
        .DIV(LINE_DIV)
    ) u_tick (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(line_tick)
    );

    genvar g;
    generate
        for (g = 0; g < NG; g = g + 1) begin : gen_addr
            // Base is stored with the low bits cleared already
            assign grp_struct_addr_o[g*32 +: 32] = {base_q[g][31:`GSR_BASE_LSB],
                                                    {`GSR_BASE_LSB{1'b0}}}; // see R1
        end
    endgenerate

    // AXI4-Lite write side: address and data taken in any order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_idx = awaddr_q[7:3];
    assign wr_grp_hit = (wr_idx < NG);
    assign wr_merged = {wstrb_q[3] ? wdata_q[31:24] : 8'h00,
                        wstrb_q[2] ? wdata_q[23:16] : 8'h00,
                        wstrb_q[1] ? wdata_q[15:8] : 8'h00,
                        wstrb_q[0] ? wdata_q[7:0] : 8'h00};
    assign new_code = wr_merged[`GSR_CODE_HI:`GSR_CODE_LO];
    assign cur_code = cur_cmd_q[`GSR_CODE_HI:`GSR_CODE_LO];
    assign cur_dir = cur_cmd_q[`GSR_DIR_BIT];
    assign cur_chan = cur_cmd_q[`GSR_CHAN_HI:`GSR_CHAN_LO];
    assign s_axi_arready = !s_axi_rvalid;
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // Lowest pending group wins; groups are served one at a time
    always @* begin
        pick_found = 1'b0;
        pick_grp = {GRP_W{1'b0}};
        for (i = 0; i < NG; i = i + 1) begin
            if (pend_q[i] && !pick_found) begin
                pick_found = 1'b1;
                pick_grp = i[GRP_W-1:0];
            end
        end
    end

    always @* begin
        case (cmd_q[pick_grp][`GSR_CODE_HI:`GSR_CODE_LO])
            `GSR_C_GLOBAL_INIT, `GSR_C_GROUP_INIT, `GSR_C_CHAN_CFG: begin
                needs_fetch = 1'b1; // see R11 see R13 see R17
            end
            default: begin
                needs_fetch = (cmd_q[pick_grp][`GSR_CODE_HI:`GSR_CODE_LO] >= `GSR_C_RD_GLOBAL)
                    && (cmd_q[pick_grp][`GSR_CODE_HI:`GSR_CODE_LO] <= `GSR_C_RD_PORT); // see R17
            end
        endcase
    end

    always @* begin
        irq_set = {`GSR_IRQ_W{1'b0}};
        irq_set[`GSR_IRQ_ACK] = ack_valid_o && ack_ready_i;
        irq_set[`GSR_IRQ_CHIP_RST] = chip_rst_pend_q && line_tick;
        // Overlapping commands are a host fault; flagged, yet still written to the command register and queued
        irq_set[`GSR_IRQ_OVERLAP] = do_wr && wr_grp_hit && awaddr_q[2]
            && (awaddr_q[11:8] == `GSR_REGION_GROUP) && wstrb_q[1]
            && (pend_q[wr_idx[GRP_W-1:0]] || (state_q != `GSR_ST_IDLE
            && cur_grp_q == wr_idx[GRP_W-1:0])); // see R6
    end

    // Read decode
    always @* begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr[11:8] == `GSR_REGION_GROUP && s_axi_araddr[7:3] < NG) begin
            if (s_axi_araddr[2]) begin
                rd_data = cmd_q[s_axi_araddr[3+GRP_W-1:3]];
            end else begin
                rd_data = base_q[s_axi_araddr[3+GRP_W-1:3]];
            end
        end else if (s_axi_araddr[11:8] == `GSR_REGION_CHAN && s_axi_araddr[7:3] < NG) begin
            if (s_axi_araddr[2]) begin
                rd_data = tx_active_o[s_axi_araddr[3+GRP_W-1:3]*NCH +: NCH];
            end else begin
                rd_data = rx_active_o[s_axi_araddr[3+GRP_W-1:3]*NCH +: NCH];
            end
        end else begin
            case (s_axi_araddr)
                `GSR_OFF_IRQ_STAT: rd_data[`GSR_IRQ_W-1:0] = irq_stat_q;
                `GSR_OFF_IRQ_MASK: rd_data[`GSR_IRQ_W-1:0] = irq_mask_q;
                `GSR_OFF_BUSY: rd_data[NG-1:0] = pend_q;
                `GSR_OFF_PORTS: rd_data[NG+1:0] = {port_en_o, port_map_o};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GSR_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? `GSR_RESP_OKAY : `GSR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GSR_RESP_OKAY;
            irq_mask_q <= {`GSR_IRQ_W{1'b0}};
            irq_stat_q <= {`GSR_IRQ_W{1'b0}};
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= ((awaddr_q[11:8] == `GSR_REGION_GROUP && wr_grp_hit)
                    || awaddr_q == `GSR_OFF_IRQ_STAT || awaddr_q == `GSR_OFF_IRQ_MASK)
                    ? `GSR_RESP_OKAY : `GSR_RESP_SLVERR;
                if (awaddr_q == `GSR_OFF_IRQ_MASK) begin
                    irq_mask_q <= wr_merged[`GSR_IRQ_W-1:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Write one to clear; a new event in the same cycle stays set
            if (do_wr && awaddr_q == `GSR_OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~wr_merged[`GSR_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
        end
    end

    // Command sequencer and the state it controls
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (j = 0; j < NG; j = j + 1) begin
                base_q[j] <= 32'h0000_0000;
                cmd_q[j] <= 32'h0000_0000;
            end
            pend_q <= {NG{1'b0}};
            state_q <= `GSR_ST_IDLE;
            cur_grp_q <= {GRP_W{1'b0}};
            cur_cmd_q <= 32'h0000_0000;
            chip_rst_pend_q <= 1'b0;
            fetch_req_o <= 1'b0;
            fetch_code_o <= 5'h00;
            fetch_grp_o <= {GRP_W{1'b0}};
            fetch_dir_o <= 1'b0;
            fetch_chan_o <= 5'h00;
            fetch_addr_o <= 32'h0000_0000;
            ack_valid_o <= 1'b0;
            ack_grp_o <= {GRP_W{1'b0}};
            ack_code_o <= 5'h00;
            chan_op_valid_o <= 1'b0;
            chan_op_o <= `GSR_OP_ACTIVATE;
            chan_grp_o <= {GRP_W{1'b0}};
            chan_dir_o <= 1'b0;
            chan_idx_o <= 5'h00;
            iq_reset_o <= 1'b0;
            port_map_o <= 2'h0;
            port_en_o <= {NG{1'b0}};
            rx_active_o <= {NG*NCH{1'b0}};
            tx_active_o <= {NG*NCH{1'b0}};
        end else begin
            chan_op_valid_o <= 1'b0;
            iq_reset_o <= 1'b0;
            if (do_wr && wr_grp_hit && awaddr_q[11:8] == `GSR_REGION_GROUP) begin
                if (!awaddr_q[2]) begin
                    base_q[wr_idx[GRP_W-1:0]] <= wr_merged & `GSR_BASE_MASK; // see R2
                end else if (wstrb_q[1]) begin
                    cmd_q[wr_idx[GRP_W-1:0]] <= wr_merged & `GSR_CMD_MASK;
                    if (new_code == `GSR_C_CHIP_RST) begin
                        chip_rst_pend_q <= 1'b1; // see R5
                    end else begin
                        pend_q[wr_idx[GRP_W-1:0]] <= 1'b1; // see R7
                    end
                end
            end
            case (state_q)
                `GSR_ST_IDLE: begin
                    if (pick_found && !chip_rst_pend_q) begin
                        pend_q[pick_grp] <= 1'b0;
                        cur_grp_q <= pick_grp;
                        cur_cmd_q <= cmd_q[pick_grp];
                        state_q <= needs_fetch ? `GSR_ST_FETCH : `GSR_ST_ACK;
                        fetch_req_o <= needs_fetch;
                        fetch_code_o <= cmd_q[pick_grp][`GSR_CODE_HI:`GSR_CODE_LO];
                        fetch_grp_o <= pick_grp;
                        fetch_dir_o <= cmd_q[pick_grp][`GSR_DIR_BIT];
                        fetch_chan_o <= cmd_q[pick_grp][`GSR_CHAN_HI:`GSR_CHAN_LO];
                        fetch_addr_o <= grp_struct_addr_o[pick_grp*32 +: 32]; // see R3
                        ack_valid_o <= !needs_fetch; // see R4 see R8 see R18
                        ack_grp_o <= pick_grp; // see R7
                        ack_code_o <= cmd_q[pick_grp][`GSR_CODE_HI:`GSR_CODE_LO];
                        chan_grp_o <= pick_grp;
                        chan_dir_o <= cmd_q[pick_grp][`GSR_DIR_BIT];
                        chan_idx_o <= cmd_q[pick_grp][`GSR_CHAN_HI:`GSR_CHAN_LO];
                        case (cmd_q[pick_grp][`GSR_CODE_HI:`GSR_CODE_LO])
                            `GSR_C_GRP_RST: begin
                                port_en_o[pick_grp >> port_map_o] <= 1'b0; // see R10
                                rx_active_o[pick_grp*NCH +: NCH] <= {NCH{1'b0}};
                                tx_active_o[pick_grp*NCH +: NCH] <= {NCH{1'b0}};
                            end
                            `GSR_C_GLOBAL_INIT, `GSR_C_RD_IRQQ: begin
                                iq_reset_o <= 1'b1; // see R11 see R17
                            end
                            `GSR_C_ACTIVATE: begin
                                chan_op_valid_o <= 1'b1; // see R15
                                chan_op_o <= `GSR_OP_ACTIVATE;
                            end
                            `GSR_C_DEACTIVATE: begin
                                chan_op_valid_o <= 1'b1; // see R15
                                chan_op_o <= `GSR_OP_DEACTIVATE;
                            end
                            `GSR_C_JUMP: begin
                                // Transmit side defers the switch to the message end
                                chan_op_valid_o <= 1'b1; // see R16
                                chan_op_o <= cmd_q[pick_grp][`GSR_DIR_BIT]
                                    ? `GSR_OP_JUMP_DEFER : `GSR_OP_ACTIVATE;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                `GSR_ST_FETCH: begin
                    if (fetch_done_i) begin
                        fetch_req_o <= 1'b0;
                        state_q <= `GSR_ST_ACK;
                        ack_valid_o <= 1'b1; // see R4
                        if (cur_code == `GSR_C_GLOBAL_INIT || cur_code == `GSR_C_RD_GLOBAL) begin
                            port_map_o <= gcfg_port_to_group_mapping_i; // see R11
                        end
                        if (cur_code == `GSR_C_GROUP_INIT || cur_code == `GSR_C_RD_PORT) begin
                            port_en_o[cur_grp_q >> port_map_o] <= 1'b1; // see R13
                        end
                    end
                end
                `GSR_ST_ACK: begin
                    if (ack_ready_i) begin
                        ack_valid_o <= 1'b0;
                        state_q <= `GSR_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= `GSR_ST_IDLE;
                end
            endcase
            // Deactivation lands on the channel flags one cycle after the op pulse
            if (chan_op_valid_o) begin
                if (chan_op_o == `GSR_OP_DEACTIVATE) begin
                    if (chan_dir_o) begin
                        tx_active_o[chan_grp_o*NCH + chan_idx_o] <= 1'b0; // see R15
                    end else begin
                        rx_active_o[chan_grp_o*NCH + chan_idx_o] <= 1'b0;
                    end
                end else if (chan_dir_o) begin
                    tx_active_o[chan_grp_o*NCH + chan_idx_o] <= 1'b1;
                end else begin
                    rx_active_o[chan_grp_o*NCH + chan_idx_o] <= 1'b1;
                end
            end
            // Waiting for the next line tick keeps completion within one period
            if (chip_rst_pend_q && line_tick) begin
                chip_rst_pend_q <= 1'b0; // see R5
                pend_q <= {NG{1'b0}};
                state_q <= `GSR_ST_IDLE;
                fetch_req_o <= 1'b0;
                ack_valid_o <= 1'b0;
                chan_op_valid_o <= 1'b0;
                iq_reset_o <= 1'b1; // see R9
                port_map_o <= 2'h0;
                port_en_o <= {NG{1'b0}};
                rx_active_o <= {NG*NCH{1'b0}};
                tx_active_o <= {NG*NCH{1'b0}};
            end
        end
    end
endmodule
